// file: hdl/sps_pkg.sv
// Purpose: shared constants for the byte serial link, both ends
// Assumes: 50 MHz pclk, byte-wide serial frames
package sps_pkg;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] TGL_LAST = 4'hf;
  localparam logic [7:0] DIV_MIN = 8'h06;
  localparam logic [7:0] TX_IDLE_BYTE = 8'hff;
  localparam logic [1:0] ROLE_SLAVE = 2'h0;
  localparam logic [1:0] ROLE_MASTER = 2'h1;
  localparam logic [1:0] ROLE_NONE = 2'h3;
  localparam logic [1:0] ROLE_LOCK_CNT = 2'h3;
  localparam int APB_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MTX = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_MRX = 8'h0c;
  localparam logic [7:0] REG_STX = 8'h10;
  localparam logic [7:0] REG_SRX = 8'h14;
  localparam int CTRL_POL_BIT = 0;
  localparam int CTRL_PHA_BIT = 1;
  localparam int CTRL_DIV_LSB = 8;
  localparam int MTX_LAST_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_MRX_BIT = 1;
  localparam int STAT_SRX_BIT = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0400;
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_RUN, ST_TRAIL} sps_mst_state_t;
endpackage

// file: hdl/sps_link_if.sv
// Purpose: serial wires between device end and far end
// Assumes: s_* is the device slave port, m_* the device master port
// Notes: all wires one-way, no tristate
`timescale 1ns/1ps
interface sps_link_if;
  logic s_clk;
  logic s_ss_n;
  logic s_mosi;
  logic s_miso;
  logic m_clk;
  logic m_ss_n;
  logic m_mosi;
  logic m_miso;
  modport dev (input s_clk, input s_ss_n, input s_mosi, input m_miso,
               output s_miso, output m_clk, output m_ss_n, output m_mosi);
  modport far (output s_clk, output s_ss_n, output s_mosi, output m_miso,
               input s_miso, input m_clk, input m_ss_n, input m_mosi);
endinterface

// file: hdl/sps_fifo.sv
// Purpose: valid/ready fifo for received bytes
// Assumes: depth a power of two
// Notes: in_ready low when full, out_valid low when empty
`timescale 1ns/1ps
module sps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;
  logic full;
  logic empty;
  assign empty = (wptr_reg == rptr_reg);
  assign full = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rptr_reg[AW-1:0]];
  always_ff @(posedge pclk) begin
    if (in_valid && !full) begin
      mem[wptr_reg[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (in_valid && !full) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (out_ready && !empty) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end
endmodule // sps_fifo

// file: hdl/sps_dev.sv
// Purpose: device end, slave or master role, bytes to and from host
// Assumes: role pins static after reset, cfg from host logic on pclk
// Notes: link inputs pass two flops, edges found on pclk
`timescale 1ns/1ps
module sps_dev (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] interface_role_pins,
  input wire logic link_up,
  output logic link_wait,
  input wire logic clock_idle_level,
  input wire logic clock_sample_phase,
  input wire logic [7:0] cfg_div,
  input wire logic cfg_half_duplex,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  output logic rx_overrun,
  sps_link_if.dev link
);
  logic [1:0] role_s1, role_s2, role_reg, lock_cnt;
  logic sclk_s1, sclk_s2, sclk_q;
  logic ss_s1, ss_s2, ss_q;
  logic mosi_s1, mosi_s2, miso_s1, miso_s2;
  logic link_wait_reg, tx_ready_reg, rx_overrun_reg;
  logic [7:0] hold_byte;
  logic hold_last, next_ok;
  logic [7:0] tx_sh, rx_sh;
  logic [2:0] bit_cnt;
  logic fresh;
  sps_pkg::sps_mst_state_t mst_state;
  logic [7:0] div_cnt;
  logic [3:0] tg_cnt;
  logic m_sclk_reg, m_ss_n_reg, m_last_reg;
  logic is_slave, is_master, same_edge, din, active;
  logic s_rise, s_fall, s_start, tgl, m_rise, m_fall, rise, fall;
  logic samp, shft, byte_done, m_load, consume, push_v, fifo_rdy, rx_fifo_in_ready;
  logic [7:0] div_eff, div_end, rx_byte;

  // role pins, synchronised then frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      role_s1 <= sps_pkg::ROLE_NONE;
      role_s2 <= sps_pkg::ROLE_NONE;
      role_reg <= sps_pkg::ROLE_NONE;
      lock_cnt <= '0;
    end else begin
      role_s1 <= interface_role_pins;
      role_s2 <= role_s1;
      if (lock_cnt != sps_pkg::ROLE_LOCK_CNT) begin
        lock_cnt <= lock_cnt + 1'b1;
        role_reg <= role_s2;
      end
    end
  end

  // link input synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_q <= 1'b0;
      ss_s1 <= 1'b1;
      ss_s2 <= 1'b1;
      ss_q <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      sclk_s1 <= link.s_clk;
      sclk_s2 <= sclk_s1;
      sclk_q <= sclk_s2;
      ss_s1 <= link.s_ss_n;
      ss_s2 <= ss_s1;
      ss_q <= ss_s2;
      mosi_s1 <= link.s_mosi;
      mosi_s2 <= mosi_s1;
      miso_s1 <= link.m_miso;
      miso_s2 <= miso_s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_wait_reg <= 1'b1;
    end else begin
      link_wait_reg <= !link_up;
    end
  end

  assign is_slave = (role_reg == sps_pkg::ROLE_SLAVE);
  assign is_master = (role_reg == sps_pkg::ROLE_MASTER);
  assign div_eff = (cfg_div < sps_pkg::DIV_MIN) ? sps_pkg::DIV_MIN : cfg_div;
  assign div_end = div_eff - 8'h01;
  assign fifo_rdy = rx_fifo_in_ready;
  assign same_edge = (clock_idle_level == clock_sample_phase);
  assign s_rise = sclk_s2 && !sclk_q;
  assign s_fall = !sclk_s2 && sclk_q;
  assign s_start = is_slave && ss_q && !ss_s2;
  assign tgl = (mst_state == sps_pkg::ST_RUN) && (div_cnt == div_end);
  assign m_rise = tgl && !m_sclk_reg;
  assign m_fall = tgl && m_sclk_reg;
  assign rise = is_master ? m_rise : s_rise;
  assign fall = is_master ? m_fall : s_fall;
  assign active = is_master ? (mst_state == sps_pkg::ST_RUN) : (is_slave && !ss_s2);
  assign samp = active && (same_edge ? rise : fall);
  assign shft = active && (same_edge ? fall : rise);
  assign din = is_master ? miso_s2 : mosi_s2;
  assign byte_done = samp && (bit_cnt == sps_pkg::BIT_LAST);
  assign rx_byte = {rx_sh[6:0], din};
  assign m_load = is_master && next_ok && fifo_rdy && (div_cnt == div_end)
                  && ((mst_state == sps_pkg::ST_IDLE)
                      || ((mst_state == sps_pkg::ST_TRAIL) && !m_last_reg));
  assign consume = m_load || (next_ok && (s_start || (byte_done && is_slave)));
  assign push_v = byte_done && link_up && !(is_master && cfg_half_duplex);

  // one-byte holding stage from host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_byte <= '0;
      hold_last <= 1'b0;
      next_ok <= 1'b0;
      tx_ready_reg <= 1'b1;
    end else if (tx_valid && tx_ready_reg) begin
      hold_byte <= tx_data;
      hold_last <= tx_last;
      next_ok <= 1'b1;
      tx_ready_reg <= 1'b0;
    end else if (consume) begin
      next_ok <= 1'b0;
      tx_ready_reg <= 1'b1;
    end
  end

  // shift engine, both roles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh <= sps_pkg::TX_IDLE_BYTE;
      rx_sh <= '0;
      bit_cnt <= '0;
      fresh <= 1'b0;
    end else if (s_start || m_load) begin
      tx_sh <= next_ok ? hold_byte : sps_pkg::TX_IDLE_BYTE;
      fresh <= clock_sample_phase;
      bit_cnt <= '0;
    end else if (!active) begin
      bit_cnt <= '0;
    end else if (samp) begin
      rx_sh <= rx_byte;
      bit_cnt <= bit_cnt + 1'b1;
      if (byte_done && is_slave) begin
        tx_sh <= next_ok ? hold_byte : sps_pkg::TX_IDLE_BYTE;
        fresh <= 1'b1;
      end
    end else if (shft) begin
      if (fresh) begin
        fresh <= 1'b0;
      end else begin
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
    end
  end

  // master clock and select sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_state <= sps_pkg::ST_IDLE;
      div_cnt <= '0;
      tg_cnt <= '0;
      m_sclk_reg <= 1'b0;
      m_ss_n_reg <= 1'b1;
      m_last_reg <= 1'b0;
    end else begin
      if (m_load) begin
        m_last_reg <= hold_last;
      end
      case (mst_state)
        sps_pkg::ST_IDLE: begin
          m_ss_n_reg <= 1'b1;
          m_sclk_reg <= clock_idle_level;
          if (div_cnt != div_end) begin
            div_cnt <= div_cnt + 8'h01;
          end else if (m_load) begin
            m_ss_n_reg <= 1'b0;
            div_cnt <= '0;
            mst_state <= sps_pkg::ST_LEAD;
          end
        end
        sps_pkg::ST_LEAD: begin
          div_cnt <= (div_cnt == div_end) ? 8'h00 : div_cnt + 8'h01;
          if (div_cnt == div_end) begin
            tg_cnt <= '0;
            mst_state <= sps_pkg::ST_RUN;
          end
        end
        sps_pkg::ST_RUN: begin
          div_cnt <= tgl ? 8'h00 : div_cnt + 8'h01;
          if (tgl) begin
            m_sclk_reg <= !m_sclk_reg;
            tg_cnt <= tg_cnt + 1'b1;
            if (tg_cnt == sps_pkg::TGL_LAST) begin
              mst_state <= sps_pkg::ST_TRAIL;
            end
          end
        end
        sps_pkg::ST_TRAIL: begin
          div_cnt <= (div_cnt == div_end) ? 8'h00 : div_cnt + 8'h01;
          if (div_cnt == div_end) begin
            tg_cnt <= '0;
            if (m_load) begin
              mst_state <= sps_pkg::ST_RUN;
            end else if (m_last_reg || !next_ok || !fifo_rdy) begin
              m_ss_n_reg <= 1'b1;
              mst_state <= sps_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          mst_state <= sps_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // receive path into fifo
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_overrun_reg <= 1'b0;
    end else begin
      rx_overrun_reg <= push_v && !rx_fifo_in_ready;
    end
  end

  sps_fifo #(.WIDTH(sps_pkg::BYTE_W), .DEPTH(sps_pkg::FIFO_DEPTH)) u_rx_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push_v),
    .in_data(rx_byte),
    .in_ready(rx_fifo_in_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );

  assign link.m_mosi = tx_sh[7];
  assign link.s_miso = tx_sh[7];
  assign link.m_clk = m_sclk_reg;
  assign link.m_ss_n = m_ss_n_reg;
  assign link_wait = link_wait_reg;
  assign tx_ready = tx_ready_reg;
  assign rx_overrun = rx_overrun_reg;
endmodule // sps_dev

// file: hdl/sps_far.sv
// Purpose: far end, master toward device slave port, slave toward device master port
// Assumes: apb software drives it, same polarity and phase as device
// Notes: two pclk cycles per apb access phase
`timescale 1ns/1ps
module sps_far (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sps_link_if.far link
);
  logic [31:0] ctrl_reg, prdata_reg, rd_mux;
  logic pready_reg, pslverr_reg, mapped, acc, wr, rd, pol, pha, same_edge;
  logic [7:0] div_end, fm_div, fs_stx, mrx_reg, srx_reg;
  logic mrx_full, srx_full;
  sps_pkg::sps_mst_state_t fm_state;
  logic [7:0] fm_tx, fm_rx, fm_div_cnt;
  logic [2:0] fm_cnt;
  logic [3:0] fm_tg;
  logic fm_fresh, fm_last, fm_sclk, fm_ss_n, fm_tgl, fm_samp, go;
  logic miso_s1, miso_s2, c_s1, c_s2, c_q, ss_s1, ss_s2, ss_q, mo_s1, mo_s2;
  logic [7:0] fs_tx, fs_rx;
  logic [2:0] fs_cnt;
  logic fs_fresh, fs_samp, fs_shft, fs_start, fs_done;

  assign pol = ctrl_reg[sps_pkg::CTRL_POL_BIT];
  assign pha = ctrl_reg[sps_pkg::CTRL_PHA_BIT];
  assign same_edge = (pol == pha);
  assign fm_div = ctrl_reg[sps_pkg::CTRL_DIV_LSB +: 8];
  assign div_end = ((fm_div < sps_pkg::DIV_MIN) ? sps_pkg::DIV_MIN : fm_div) - 8'h01;
  assign acc = psel && penable && pready_reg;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign go = wr && (paddr == sps_pkg::REG_MTX) && (fm_state == sps_pkg::ST_IDLE);

  // apb read decode
  always_comb begin
    rd_mux = '0;
    mapped = 1'b1;
    case (paddr)
      sps_pkg::REG_CTRL: rd_mux = ctrl_reg;
      sps_pkg::REG_MTX: rd_mux = '0;
      sps_pkg::REG_STAT: begin
        rd_mux[sps_pkg::STAT_BUSY_BIT] = (fm_state != sps_pkg::ST_IDLE);
        rd_mux[sps_pkg::STAT_MRX_BIT] = mrx_full;
        rd_mux[sps_pkg::STAT_SRX_BIT] = srx_full;
      end
      sps_pkg::REG_MRX: rd_mux = {24'h000000, mrx_reg};
      sps_pkg::REG_STX: rd_mux = {24'h000000, fs_stx};
      sps_pkg::REG_SRX: rd_mux = {24'h000000, srx_reg};
      default: mapped = 1'b0;
    endcase
  end

  // apb slave, one wait cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      ctrl_reg <= sps_pkg::CTRL_RST;
      fs_stx <= sps_pkg::TX_IDLE_BYTE;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      if (psel && penable && !pready_reg) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_reg <= !mapped;
      end
      if (wr && paddr == sps_pkg::REG_CTRL) begin
        ctrl_reg <= pwdata;
      end
      if (wr && paddr == sps_pkg::REG_STX) begin
        fs_stx <= pwdata[7:0];
      end
    end
  end

  // synchronisers for device master wires and device slave miso
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {miso_s1, miso_s2, c_s1, c_s2, c_q, mo_s1, mo_s2} <= '0;
      {ss_s1, ss_s2, ss_q} <= 3'h7;
    end else begin
      miso_s1 <= link.s_miso;
      miso_s2 <= miso_s1;
      c_s1 <= link.m_clk;
      c_s2 <= c_s1;
      c_q <= c_s2;
      ss_s1 <= link.m_ss_n;
      ss_s2 <= ss_s1;
      ss_q <= ss_s2;
      mo_s1 <= link.m_mosi;
      mo_s2 <= mo_s1;
    end
  end

  // far master: one byte per MTX write
  assign fm_tgl = (fm_state == sps_pkg::ST_RUN) && (fm_div_cnt == div_end);
  assign fm_samp = fm_tgl && ((!fm_sclk) == same_edge);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fm_state <= sps_pkg::ST_IDLE;
      {fm_tx, fm_rx, fm_div_cnt, mrx_reg} <= '0;
      {fm_cnt, fm_tg} <= '0;
      {fm_fresh, fm_last, fm_sclk, mrx_full} <= '0;
      fm_ss_n <= 1'b1;
    end else begin
      if (rd && paddr == sps_pkg::REG_MRX) begin
        mrx_full <= 1'b0;
      end
      fm_div_cnt <= (fm_state == sps_pkg::ST_IDLE || fm_div_cnt == div_end) ? 8'h00
                    : fm_div_cnt + 8'h01;
      case (fm_state)
        sps_pkg::ST_IDLE: begin
          fm_sclk <= pol;
          if (go) begin
            fm_tx <= pwdata[7:0];
            fm_last <= pwdata[sps_pkg::MTX_LAST_BIT];
            fm_fresh <= pha;
            fm_cnt <= '0;
            fm_tg <= '0;
            fm_ss_n <= 1'b0;
            fm_state <= sps_pkg::ST_LEAD;
          end
        end
        sps_pkg::ST_LEAD: begin
          fm_state <= (fm_div_cnt == div_end) ? sps_pkg::ST_RUN : sps_pkg::ST_LEAD;
        end
        sps_pkg::ST_RUN: begin
          if (fm_tgl) begin
            fm_sclk <= !fm_sclk;
            fm_tg <= fm_tg + 1'b1;
            fm_state <= (fm_tg == sps_pkg::TGL_LAST) ? sps_pkg::ST_TRAIL : sps_pkg::ST_RUN;
            if (fm_samp) begin
              fm_rx <= {fm_rx[6:0], miso_s2};
              fm_cnt <= fm_cnt + 1'b1;
              if (fm_cnt == sps_pkg::BIT_LAST) begin
                mrx_reg <= {fm_rx[6:0], miso_s2};
                mrx_full <= 1'b1;
              end
            end else if (fm_fresh) begin
              fm_fresh <= 1'b0;
            end else begin
              fm_tx <= {fm_tx[6:0], 1'b0};
            end
          end
        end
        sps_pkg::ST_TRAIL: begin
          if (fm_div_cnt == div_end) begin
            fm_ss_n <= fm_ss_n | fm_last;
            fm_state <= sps_pkg::ST_IDLE;
          end
        end
        default: fm_state <= sps_pkg::ST_IDLE;
      endcase
    end
  end

  // far slave toward device master port
  assign fs_start = ss_q && !ss_s2;
  assign fs_samp = !ss_s2 && (same_edge ? (c_s2 && !c_q) : (!c_s2 && c_q));
  assign fs_shft = !ss_s2 && (same_edge ? (!c_s2 && c_q) : (c_s2 && !c_q));
  assign fs_done = fs_samp && (fs_cnt == sps_pkg::BIT_LAST);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {fs_tx, fs_rx, srx_reg} <= '0;
      fs_cnt <= '0;
      {fs_fresh, srx_full} <= '0;
    end else begin
      if (rd && paddr == sps_pkg::REG_SRX) begin
        srx_full <= 1'b0;
      end
      if (fs_start) begin
        fs_tx <= fs_stx;
        fs_fresh <= pha;
        fs_cnt <= '0;
      end else if (ss_s2) begin
        fs_cnt <= '0;
      end else if (fs_samp) begin
        fs_rx <= {fs_rx[6:0], mo_s2};
        fs_cnt <= fs_cnt + 1'b1;
        if (fs_done) begin
          srx_reg <= {fs_rx[6:0], mo_s2};
          srx_full <= 1'b1;
          fs_tx <= fs_stx;
          fs_fresh <= 1'b1;
        end
      end else if (fs_shft) begin
        if (fs_fresh) begin
          fs_fresh <= 1'b0;
        end else begin
          fs_tx <= {fs_tx[6:0], 1'b0};
        end
      end
    end
  end

  assign link.s_clk = fm_sclk;
  assign link.s_ss_n = fm_ss_n;
  assign link.s_mosi = fm_tx[7];
  assign link.m_miso = fs_tx[7];
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
endmodule // sps_far

// file: tb/sps_link_monitor.sv
// Purpose: wire checks between the device end and the far end
// Assumes: both ends share polarity and phase, half period at least six pclk
// Notes: single pclk domain
`timescale 1ns/1ps
module sps_link_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clock_idle_level,
  input wire logic clock_sample_phase,
  input wire logic s_clk,
  input wire logic s_ss_n,
  input wire logic s_mosi,
  input wire logic s_miso,
  input wire logic m_clk,
  input wire logic m_ss_n,
  input wire logic m_mosi,
  input wire logic m_miso
);
  logic samp_lvl;
  assign samp_lvl = !(clock_idle_level ^ clock_sample_phase);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_mclk_idle_move: assert property (
    $changed(m_clk) && m_ss_n |-> m_clk == clock_idle_level)
    else $error("master clock left idle level outside frame");
  a_sclk_idle_move: assert property (
    $changed(s_clk) && s_ss_n |-> s_clk == clock_idle_level)
    else $error("far clock left idle level outside frame");
  a_mss_clk_idle: assert property (
    $changed(m_ss_n) |-> m_clk == clock_idle_level && $stable(m_clk))
    else $error("master select moved with clock active");
  a_sss_clk_idle: assert property (
    $changed(s_ss_n) |-> s_clk == clock_idle_level && $stable(s_clk))
    else $error("far select moved with clock active");
  a_mosi_at_sample: assert property (
    $changed(m_clk) && !m_ss_n && m_clk == samp_lvl |-> $stable(m_mosi) ##1 $stable(m_mosi))
    else $error("master data moved at sample edge");
  a_smosi_at_sample: assert property (
    $changed(s_clk) && !s_ss_n && s_clk == samp_lvl |-> $stable(s_mosi) ##1 $stable(s_mosi))
    else $error("far data moved at sample edge");
  a_mclk_half_period: assert property (
    $changed(m_clk) |=> $stable(m_clk)[*3])
    else $error("master clock half period short");
  a_mss_lead_time: assert property (
    $fell(m_ss_n) |-> $stable(m_clk)[*4])
    else $error("master clock edge too soon after select");
  c_master_frame: cover property ($fell(m_ss_n));
  c_far_frame: cover property ($fell(s_ss_n));
  c_high_idle: cover property (clock_idle_level && $fell(m_ss_n));
endmodule // sps_link_monitor

// file: tb/tb_spi_master_slave_port.sv
// Purpose: both ends joined, device user side and far apb driven
// Assumes: half period six pclk after clamping, role set by reset
// Notes: expected bytes kept in a queue
`timescale 1ns/1ps
module tb_spi_master_slave_port;
  logic pclk, presetn, link_up, link_wait, pol, pha, hd, tx_valid, tx_last, tx_ready;
  logic rx_valid, rx_ready, rx_overrun, psel, penable, pwrite, pready, pslverr, perr;
  logic [1:0] pins;
  logic [7:0] cfg_div, tx_data, rx_data, paddr, b;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] seed;
  logic [7:0] exp_q[$];
  int num_errors, compares, overruns;
  sps_link_if sps_link_if_inst ();
  sps_dev sps_dev_inst (.pclk(pclk), .presetn(presetn), .interface_role_pins(pins),
    .link_up(link_up), .link_wait(link_wait), .clock_idle_level(pol),
    .clock_sample_phase(pha), .cfg_div(cfg_div), .cfg_half_duplex(hd), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
    .link(sps_link_if_inst.dev));
  sps_far sps_far_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(sps_link_if_inst.far));
  sps_link_monitor sps_link_monitor_inst (.pclk(pclk), .presetn(presetn),
    .clock_idle_level(pol), .clock_sample_phase(pha), .s_clk(sps_link_if_inst.s_clk),
    .s_ss_n(sps_link_if_inst.s_ss_n), .s_mosi(sps_link_if_inst.s_mosi),
    .s_miso(sps_link_if_inst.s_miso), .m_clk(sps_link_if_inst.m_clk),
    .m_ss_n(sps_link_if_inst.m_ss_n), .m_mosi(sps_link_if_inst.m_mosi),
    .m_miso(sps_link_if_inst.m_miso));
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    if (rx_overrun === 1'b1) overruns++;
  end
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done();
    if (num_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic reset_dut(input logic [1:0] r);
    presetn <= 1'b0;
    pins <= r;
    pol <= 1'b0;
    pha <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  task automatic set_mode(input int m);
    pol <= m[1];
    pha <= m[0];
    repeat (4) @(posedge pclk);
    apb(1'b1, sps_pkg::REG_CTRL, {16'h0, 8'h04, 6'h0, m[0], m[1]});
  endtask
  task automatic send_mtx(input logic [8:0] v);
    apb(1'b1, sps_pkg::REG_MTX, {23'h0, v});
    repeat (4) @(posedge pclk);
    do apb(1'b0, sps_pkg::REG_STAT, 32'h0); while (rd[0] !== 1'b0);
  endtask
  task automatic tx_put(input logic [7:0] d, input logic l);
    tx_data <= d;
    tx_last <= l;
    tx_valid <= 1'b1;
    do @(posedge pclk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask
  task automatic pop_rx();
    @(posedge pclk);
    while (rx_valid !== 1'b1) @(posedge pclk);
    chk("rx_data", {24'h0, exp_q.pop_front()}, {24'h0, rx_data});
    rx_ready <= 1'b1;
    @(posedge pclk);
    rx_ready <= 1'b0;
  endtask
  task automatic srx_chk(input logic [7:0] d);
    do apb(1'b0, sps_pkg::REG_STAT, 32'h0); while (rd[2] !== 1'b1);
    apb(1'b0, sps_pkg::REG_SRX, 32'h0);
    chk("srx", {24'h0, d}, {24'h0, rd[7:0]});
  endtask
  initial begin
    #(20 * 40000);
    num_errors++;
    test_done();
  end
  initial begin
    pclk = 0; link_up = 0; hd = 0; tx_valid = 0; tx_last = 0;
    rx_ready = 0; psel = 0; penable = 0; pwrite = 0; cfg_div = 8'h04;
    tx_data = 0; paddr = 0; pwdata = 0; seed = 16'hacff;
    reset_dut(2'h0);
    apb(1'b0, sps_pkg::REG_CTRL, 32'h0);
    chk("ctrl_reset", sps_pkg::CTRL_RST, rd);
    chk("link_wait", 32'h1, {31'h0, link_wait});
    send_mtx({1'b1, 8'h5a});
    repeat (20) @(posedge pclk);
    chk("early_rx", 32'h0, {31'h0, rx_valid});
    link_up <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("link_wait", 32'h0, {31'h0, link_wait});
    for (int m = 0; m < 4; m++) begin
      set_mode(m);
      b = rnd();
      tx_put(b, 1'b0);
      exp_q.push_back(rnd());
      send_mtx({1'b0, exp_q[0]});
      apb(1'b0, sps_pkg::REG_MRX, 32'h0);
      chk("mrx", {24'h0, b}, {24'h0, rd[7:0]});
      exp_q.push_back(rnd());
      send_mtx({1'b1, exp_q[1]});
      apb(1'b0, sps_pkg::REG_MRX, 32'h0);
      chk("mrx_idle", 32'hff, {24'h0, rd[7:0]});
      pop_rx();
      pop_rx();
    end
    for (int i = 0; i < 17; i++) begin
      b = rnd();
      if (i < 16) exp_q.push_back(b);
      send_mtx({1'b1, b});
    end
    chk("overruns", 32'h1, overruns);
    repeat (16) pop_rx();
    @(posedge pclk);
    chk("rx_empty", 32'h0, {31'h0, rx_valid});
    reset_dut(2'h1);
    for (int m = 0; m < 4; m++) begin
      set_mode(m);
      exp_q.push_back(rnd());
      apb(1'b1, sps_pkg::REG_STX, {24'h0, exp_q[0]});
      b = rnd();
      tx_put(b, 1'b1);
      pop_rx();
      srx_chk(b);
    end
    hd <= 1'b1;
    b = rnd();
    tx_put(b, 1'b1);
    srx_chk(b);
    repeat (20) @(posedge pclk);
    chk("half_duplex_rx", 32'h0, {31'h0, rx_valid});
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, perr});
    test_done();
  end
endmodule // tb_spi_master_slave_port
